/* design/calendar_alarm_power_control.sv */
// Alarm, repeat, calibration tick and power-control logic with Wishbone registers
// Assumes the calendar digits arrive from logic on the same clock, in BCD
//
// Our own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module calendar_alarm_power_control
  import alarm_power_pkg::*;
#(
  parameter int HALF_SEC_DIV = HALF_SEC_CYCLES,
  parameter int PWC_DIV = PWC_PERIOD_CYCLES
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire calendar_s calendar_i,
  input wire logic wake_event_i,
  output logic half_tick_o,
  output logic cal_adjust_o,
  output logic alarm_irq_o,
  output logic alarm_pulse_o,
  output logic power_ctrl_signal_o,
  output logic clock_pin_o,
  output logic sample_window_o,
  output logic wake_seen_o
);

  if (HALF_SEC_DIV < 2 || PWC_DIV < 2)
  begin : g_div_check
    $error("Dividers must be at least 2");
  end

  function automatic logic [3:0] dig_eq(input logic [3:0] a, input logic [3:0] b);
    return (a == b) ? 4'hF : 4'h0;
  endfunction

  // ----------------------------------------
  // Dividers
  // ----------------------------------------
  logic [31:0] half_cnt_q, half_cnt_d, pwc_cnt_q, pwc_cnt_d;
  logic half_tick, pwc_tick;
  always_comb
  begin
    half_tick = (half_cnt_q == 32'(HALF_SEC_DIV - 1));
    pwc_tick = (pwc_cnt_q == 32'(PWC_DIV - 1));
    half_cnt_d = half_tick ? 32'h0 : half_cnt_q + 32'h1;
    pwc_cnt_d = pwc_tick ? 32'h0 : pwc_cnt_q + 32'h1;
  end

  // Sync-window flag: high for the two cycles before a half-second update
  logic sync_flag;
  assign sync_flag = (half_cnt_q >= 32'(HALF_SEC_DIV - 2));

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] acfg_q, acfg_d, date_q, date_d, time_q, time_d, win_q, win_d;
  logic [15:0] ccfg_q, ccfg_d, pwcr_q, pwcr_d;
  logic ack_q, ack_d, wr, rd;
  logic [31:0] dat_q, dat_d;
  logic fire, pulse_q, pulse_d, irq_q, irq_d;
  logic [6:0] last_secs_q, last_secs_d;
  logic cal_q, cal_d;
  logic wake_q, wake_d, wake_meta_q, wake_sync_q;
  pwc_state_e st_q, st_d;
  logic [7:0] win_cnt_q, win_cnt_d;

  assign wr = cyc_i && stb_i && we_i && !ack_q;
  assign rd = cyc_i && stb_i && !we_i && !ack_q;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = old;
    if (s[0])
      merge[7:0] = d[7:0];
    if (s[1])
      merge[15:8] = d[15:8];
    return merge;
  endfunction

  // ----------------------------------------
  // Alarm match
  // ----------------------------------------
  logic match;
  logic [3:0] m;
  always_comb
  begin
    m = acfg_q[MASK_LSB +: 4];
    match = 1'b1;
    if (m != MASK_HALF && calendar_i.half)
      match = 1'b0;
    if (m >= MASK_10SEC && !(&dig_eq(calendar_i.sec_one, time_q[3:0])))
      match = 1'b0;
    if (m >= MASK_MIN && calendar_i.sec_ten[2:0] != time_q[6:4])
      match = 1'b0;
    if (m >= MASK_10MIN && calendar_i.min_one != time_q[11:8])
      match = 1'b0;
    if (m >= MASK_HOUR && calendar_i.min_ten[2:0] != time_q[14:12])
      match = 1'b0;
    if (m >= MASK_DAY && {calendar_i.hour_ten[1:0], calendar_i.hour_one} != date_q[5:0])
      match = 1'b0;
    // Weekday sits just above the hours in the date word
    if (m == MASK_WEEK && calendar_i.wday[2:0] != date_q[8:6])
      match = 1'b0;
    if (m >= MASK_MONTH && {calendar_i.day_ten[1:0], calendar_i.day_one} != win_q[5:0])
      match = 1'b0;
    if (m == MASK_YEAR && {calendar_i.month_ten[0], calendar_i.month_one} != win_q[10:6])
      match = 1'b0;
    if (m > MASK_YEAR)
      match = 1'b0;
  end

  // Evaluated once per tick, so a lasting match fires one alarm on every half-second tick
  assign fire = half_tick && ccfg_q[CLOCK_EN_BIT] && acfg_q[ALARM_ENABLE_BIT] && match;

  // ----------------------------------------
  // Next-state
  // ----------------------------------------
  always_comb
  begin
    acfg_d = acfg_q;
    date_d = date_q;
    time_d = time_q;
    win_d = win_q;
    ccfg_d = ccfg_q;
    pwcr_d = pwcr_q;
    ack_d = cyc_i && stb_i && !ack_q;
    dat_d = dat_q;
    if (wr)
    begin
      case (adr_i)
        CLOCK_CONFIG_OFS: ccfg_d = merge(ccfg_q, dat_i, sel_i);
        ALARM_CONFIG_OFS: acfg_d = merge(acfg_q, dat_i, sel_i);
        ALARM_DATE_OFS: date_d = merge(date_q, dat_i, sel_i);
        ALARM_TIME_OFS: time_d = merge(time_q, dat_i, sel_i);
        POWER_CTRL_OFS: pwcr_d = merge(pwcr_q, dat_i, sel_i);
        WINDOW_OFS: win_d = merge(win_q, dat_i, sel_i);
        default: ;
      endcase
    end
    if (rd)
    begin
      case (adr_i)
        CALENDAR_OFS: dat_d = {8'h00, calendar_i[24:1]};
        CLOCK_CONFIG_OFS: dat_d = {16'h0000, ccfg_q[15:13], sync_flag, ccfg_q[11:0]};
        ALARM_CONFIG_OFS: dat_d = {16'h0000, acfg_q};
        ALARM_DATE_OFS: dat_d = {16'h0000, date_q};
        ALARM_TIME_OFS: dat_d = {16'h0000, time_q};
        POWER_CTRL_OFS: dat_d = {16'h0000, pwcr_q[15:2], st_q == PWC_SAMP, st_q != PWC_IDLE};
        WINDOW_OFS: dat_d = {16'h0000, win_q};
        default: dat_d = 32'h0;
      endcase
    end
    // Hardware repeat handling beats a software write in the same cycle
    if (fire)
    begin
      if (acfg_q[7:0] != 8'h00)
        acfg_d[7:0] = acfg_q[7:0] - 8'h01;
      else if (acfg_q[ENDLESS_BIT])
        acfg_d[7:0] = COUNT_WRAP;
      else
        acfg_d[ALARM_ENABLE_BIT] = 1'b0;
    end
  end

  // Calibration tick and alarm outputs
  always_comb
  begin
    last_secs_d = {calendar_i.sec_ten[2:0], calendar_i.sec_one};
    cal_d = 1'b0;
    if (ccfg_q[CLOCK_EN_BIT] && last_secs_d != last_secs_q && calendar_i.sec_one == 4'h0
        && (calendar_i.sec_ten[2:0] == 3'h0 || calendar_i.sec_ten[2:0] == 3'h3))
      cal_d = 1'b1;
    if (ccfg_q[CLOCK_EN_BIT] && last_secs_d != last_secs_q && calendar_i.sec_one == 4'h5
        && (calendar_i.sec_ten[2:0] == 3'h1 || calendar_i.sec_ten[2:0] == 3'h4))
      cal_d = 1'b1;
    pulse_d = fire ? !pulse_q : pulse_q;
    irq_d = fire;
  end

  // ----------------------------------------
  // Power control
  // ----------------------------------------
  always_comb
  begin
    st_d = st_q;
    win_cnt_d = win_cnt_q;
    wake_d = wake_q;
    case (st_q)
      PWC_IDLE:
      begin
        if (fire && pwcr_q[PWC_EN_BIT])
        begin
          if (win_q[15:8] != 8'h00)
          begin
            st_d = PWC_STAB;
            win_cnt_d = win_q[15:8];
          end
          else if (win_q[7:0] != 8'h00)
          begin
            st_d = PWC_SAMP;
            win_cnt_d = win_q[7:0];
          end
        end
      end
      PWC_STAB:
      begin
        if (pwc_tick)
        begin
          win_cnt_d = win_cnt_q - 8'h01;
          if (win_cnt_q == 8'h01)
          begin
            win_cnt_d = win_q[7:0];
            st_d = (win_q[7:0] == 8'h00) ? PWC_IDLE : PWC_SAMP;
          end
        end
      end
      PWC_SAMP:
      begin
        if (pwc_tick && win_q[7:0] != SAMPLE_ALWAYS)
        begin
          win_cnt_d = win_cnt_q - 8'h01;
          if (win_cnt_q == 8'h01)
            st_d = PWC_IDLE;
        end
      end
      default: st_d = PWC_IDLE;
    endcase
    if (sample_window_o && wake_sync_q)
      wake_d = 1'b1;
    if (rd && adr_i == POWER_CTRL_OFS)
      wake_d = sample_window_o && wake_sync_q;
  end

  logic pwc_active;
  assign pwc_active = (st_q != PWC_IDLE);
  assign sample_window_o = (st_q == PWC_SAMP) || (win_q[7:0] == SAMPLE_ALWAYS);

  // ----------------------------------------
  // Flip-flops
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      half_cnt_q <= 32'h0;
      pwc_cnt_q <= 32'h0;
      acfg_q <= ALARM_CONFIG_RST;
      date_q <= 16'h0000;
      time_q <= 16'h0000;
      win_q <= WINDOW_RST;
      ccfg_q <= 16'h0000;
      pwcr_q <= 16'h0000;
      ack_q <= 1'b0;
      dat_q <= 32'h0;
      pulse_q <= 1'b0;
      irq_q <= 1'b0;
      last_secs_q <= 7'h00;
      cal_q <= 1'b0;
      st_q <= PWC_IDLE;
      win_cnt_q <= 8'h00;
      wake_q <= 1'b0;
      wake_meta_q <= 1'b0;
      wake_sync_q <= 1'b0;
    end
    else
    begin
      half_cnt_q <= half_cnt_d;
      pwc_cnt_q <= pwc_cnt_d;
      acfg_q <= acfg_d;
      date_q <= date_d;
      time_q <= time_d;
      win_q <= win_d;
      ccfg_q <= ccfg_d;
      pwcr_q <= pwcr_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
      pulse_q <= pulse_d;
      irq_q <= irq_d;
      last_secs_q <= last_secs_d;
      cal_q <= cal_d;
      st_q <= st_d;
      win_cnt_q <= win_cnt_d;
      wake_q <= wake_d;
      wake_meta_q <= wake_event_i;
      wake_sync_q <= wake_meta_q;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;
  assign half_tick_o = half_tick;
  assign cal_adjust_o = cal_q;
  assign alarm_irq_o = irq_q;
  assign alarm_pulse_o = pulse_q;
  assign wake_seen_o = wake_q;
  // Polarity inverts the active level of the switch drive
  assign power_ctrl_signal_o = pwc_active ^ pwcr_q[PWC_POL_BIT];
  // Pin carries power control only with output enabled and source 11
  assign clock_pin_o = (ccfg_q[PIN_OE_BIT] && ccfg_q[PIN_SEL_LSB +: 2] == PIN_SEL_PWC)
                       ? power_ctrl_signal_o : pulse_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_fire_last;
    fire && acfg_q[7:0] == 8'h00 && !acfg_q[ENDLESS_BIT];
  endsequence

  property p_irq_on_fire;
    @(posedge clk_i) disable iff (rst_i) fire |=> alarm_irq_o;
  endproperty
  a_irq_on_fire: assert property (p_irq_on_fire) else $error("No irq after alarm");

  property p_pulse_toggle;
    @(posedge clk_i) disable iff (rst_i) fire |=> alarm_pulse_o != $past(alarm_pulse_o);
  endproperty
  a_pulse_toggle: assert property (p_pulse_toggle) else $error("Pulse did not toggle");

  property p_last_clears;
    @(posedge clk_i) disable iff (rst_i) s_fire_last |=> !acfg_q[ALARM_ENABLE_BIT];
  endproperty
  a_last_clears: assert property (p_last_clears) else $error("Enable not cleared");

  property p_decrement;
    @(posedge clk_i) disable iff (rst_i)
      fire && acfg_q[7:0] != 8'h00 |=> acfg_q[7:0] == $past(acfg_q[7:0]) - 8'h01;
  endproperty
  a_decrement: assert property (p_decrement) else $error("Count not decremented");

  property p_wrap;
    @(posedge clk_i) disable iff (rst_i)
      fire && acfg_q[7:0] == 8'h00 && acfg_q[ENDLESS_BIT] |=> acfg_q[7:0] == 8'hFF
      && acfg_q[ALARM_ENABLE_BIT];
  endproperty
  a_wrap: assert property (p_wrap) else $error("Endless repeat did not wrap");

  property p_fire_on_tick;
    @(posedge clk_i) disable iff (rst_i) alarm_irq_o |-> $past(half_tick);
  endproperty
  a_fire_on_tick: assert property (p_fire_on_tick) else $error("Alarm off tick");

  property p_stab_zero;
    @(posedge clk_i) disable iff (rst_i)
      st_q == PWC_IDLE && fire && pwcr_q[PWC_EN_BIT] && win_q[15:8] == 8'h00
      && win_q[7:0] != 8'h00 |=> st_q == PWC_SAMP;
  endproperty
  a_stab_zero: assert property (p_stab_zero) else $error("Sample did not start");

  property p_polarity;
    @(posedge clk_i) disable iff (rst_i)
      power_ctrl_signal_o == ((st_q != PWC_IDLE) != pwcr_q[PWC_POL_BIT]);
  endproperty
  a_polarity: assert property (p_polarity) else $error("Power control polarity wrong");

  property p_always_sample;
    @(posedge clk_i) disable iff (rst_i) win_q[7:0] == 8'hFF |-> sample_window_o;
  endproperty
  a_always_sample: assert property (p_always_sample) else $error("Sample not held");

endmodule
`default_nettype wire

/* pkg/alarm_power_pkg.sv */
// Constants, field layouts and carriers for the alarm and power-control block
// Assumes a single 100 MHz clock and a classic Wishbone register port
// What this block does
// - Calibration adjust is applied to the timer every fifteen seconds
// - Config bit 15 enables alarm; hardware clears it unless repeats remain
// - Mask field bits 13:10 selects which calendar digits must match
// - Mask codes 0000 to 1001 give half-second through yearly alarms
// - Repeat count bits 7:0; zero without endless repeat gives one alarm
// - Each alarm decrements count; without endless repeat, alarm at zero is last and clears enable
// - With endless repeat bit 14 set, count wraps from zero to FFh
// - Every alarm event raises the interrupt request
// - Alarm pulse output toggles each alarm, synchronous to block clock
// - Power control switches device on, waits, samples, then switches off
// - Polarity bit 14 selects active level of power-control output
// - Stability window counts N power-control periods; zero skips it
// - Sample window counts N periods; all ones samples permanently
// - Alarm value holds BCD month, day, weekday 0 to 6, hours, minutes, seconds
package alarm_power_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CALENDAR_OFS = 8'h00;
  localparam logic [7:0] CLOCK_CONFIG_OFS = 8'h04;
  localparam logic [7:0] ALARM_CONFIG_OFS = 8'h08;
  localparam logic [7:0] ALARM_DATE_OFS = 8'h0C;
  localparam logic [7:0] ALARM_TIME_OFS = 8'h10;
  localparam logic [7:0] POWER_CTRL_OFS = 8'h14;
  localparam logic [7:0] WINDOW_OFS = 8'h18;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int ALARM_ENABLE_BIT = 15;
  localparam int ENDLESS_BIT = 14;
  localparam int MASK_LSB = 10;
  localparam int CLOCK_EN_BIT = 15;
  localparam int SYNC_FLAG_BIT = 12;
  localparam int PIN_OE_BIT = 10;
  localparam int PIN_SEL_LSB = 8;
  localparam int PWC_EN_BIT = 15;
  localparam int PWC_POL_BIT = 14;
  localparam int PWC_SAMPLE_BIT = 1;
  localparam int PWC_ON_BIT = 0;
  localparam int STAB_LSB = 8;

  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [15:0] ALARM_CONFIG_RST = 16'h0000;
  localparam logic [15:0] WINDOW_RST = 16'h0000;
  localparam logic [7:0] COUNT_WRAP = 8'hFF;
  localparam logic [7:0] SAMPLE_ALWAYS = 8'hFF;
  localparam logic [1:0] PIN_SEL_PWC = 2'h3;
  localparam logic [3:0] MASK_HALF = 4'h0;
  localparam logic [3:0] MASK_SEC = 4'h1;
  localparam logic [3:0] MASK_10SEC = 4'h2;
  localparam logic [3:0] MASK_MIN = 4'h3;
  localparam logic [3:0] MASK_10MIN = 4'h4;
  localparam logic [3:0] MASK_HOUR = 4'h5;
  localparam logic [3:0] MASK_DAY = 4'h6;
  localparam logic [3:0] MASK_WEEK = 4'h7;
  localparam logic [3:0] MASK_MONTH = 4'h8;
  localparam logic [3:0] MASK_YEAR = 4'h9;
  localparam logic [6:0] CAL_SECS_STEP = 7'h15;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int HALF_SEC_MS = 500;
  localparam int HALF_SEC_CYCLES = CLK_HZ / 1000 * HALF_SEC_MS;
  localparam int PWC_PERIOD_US = 1000;
  localparam int PWC_PERIOD_CYCLES = CLK_HZ / 1_000_000 * PWC_PERIOD_US;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] month_ten;
    logic [3:0] month_one;
    logic [3:0] day_ten;
    logic [3:0] day_one;
    logic [3:0] wday;
    logic [3:0] hour_ten;
    logic [3:0] hour_one;
    logic [3:0] min_ten;
    logic [3:0] min_one;
    logic [3:0] sec_ten;
    logic [3:0] sec_one;
    logic half;
  } calendar_s;

  typedef enum logic [2:0] {
    PWC_IDLE = 3'b001,
    PWC_STAB = 3'b010,
    PWC_SAMP = 3'b100
  } pwc_state_e;

endpackage

/* tb/calendar_alarm_power_control_test.sv */
// Self-checking bench for the alarm and power-control block
// Assumes one 100 MHz clock and the external device model on the pin
`timescale 1ns/100ps
`default_nettype none
module calendar_alarm_power_control_test;
  import alarm_power_pkg::*;
  localparam int HDIV = 40;
  localparam int PDIV = 4;
  typedef struct packed {logic [3:0] m; logic [15:0] t; logic [15:0] d; logic f;} row_s;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, pol_b = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack_o, wake_event_i, half_tick_o, cal_adjust_o, alarm_irq_o, alarm_pulse_o;
  logic power_ctrl_signal_o, clock_pin_o, sample_window_o, wake_seen_o;
  calendar_s cal;
  int mismatches = 0, compares = 0;
  int irq_n = 0, cal_n = 0, on_n = 0, samp_n = 0, pin_n = 0, ht_n = 0;
  // Calendar is 05:34:12, weekday 3, day and month 00
  row_s rows[14] = '{'{4'h0, 16'h0000, 16'h0000, 1'b1}, '{4'h1, 16'h0000, 16'h0000, 1'b1},
    '{4'h2, 16'h3412, 16'h00C5, 1'b1}, '{4'h2, 16'h3413, 16'h00C5, 1'b0},
    '{4'h3, 16'h3402, 16'h00C5, 1'b0}, '{4'h4, 16'h3312, 16'h00C5, 1'b0},
    '{4'h5, 16'h3412, 16'h00C5, 1'b1}, '{4'h6, 16'h3412, 16'h00C4, 1'b0},
    '{4'h6, 16'h3412, 16'h00C5, 1'b1}, '{4'h7, 16'h3412, 16'h0105, 1'b0},
    '{4'h7, 16'h3412, 16'h00C5, 1'b1}, '{4'h8, 16'h3412, 16'h00C5, 1'b1},
    '{4'h9, 16'h3412, 16'h00C5, 1'b1}, '{4'hA, 16'h3412, 16'h00C5, 1'b0}};
  // Seconds value, bit 8 set where an adjust pulse is due
  logic [8:0] secs[6] = '{9'h115, 9'h016, 9'h130, 9'h145, 9'h100, 9'h044};

  calendar_alarm_power_control #(.HALF_SEC_DIV(HDIV), .PWC_DIV(PDIV)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .calendar_i(cal), .wake_event_i(wake_event_i), .half_tick_o(half_tick_o),
    .cal_adjust_o(cal_adjust_o), .alarm_irq_o(alarm_irq_o), .alarm_pulse_o(alarm_pulse_o),
    .power_ctrl_signal_o(power_ctrl_signal_o), .clock_pin_o(clock_pin_o),
    .sample_window_o(sample_window_o), .wake_seen_o(wake_seen_o));

  ext_device_model dev_u (.clk_i(clk_i), .rst_i(rst_i), .pin_i(clock_pin_o),
    .active_low_i(pol_b), .wake_o(wake_event_i));

  always #5 clk_i = ~clk_i;

  // ----------------------------------------
  // Event counters, sampled mid-cycle so they never race the bench
  // ----------------------------------------
  always @(negedge clk_i)
  begin
    if (alarm_irq_o === 1'b1) irq_n++;
    if (half_tick_o === 1'b1) ht_n++;
    if (cal_adjust_o === 1'b1) cal_n++;
    if (power_ctrl_signal_o === ~pol_b) on_n++;
    if (sample_window_o === 1'b1) samp_n++;
    if (clock_pin_o !== power_ctrl_signal_o) pin_n++;
  end

  task automatic stop_test();
    if (mismatches == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_reg({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Classic single cycle; the request is held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [15:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'h3;
    dat_i <= {16'h0000, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      mismatches++;
      stop_test();
    end
    q = dat_o[15:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk_reg(q, exp);
  endtask

  task automatic wait_irq();
    int n0;
    n0 = irq_n;
    for (int i = 0; i < 4 * HDIV && irq_n == n0; i++)
      @(posedge clk_i);
    if (irq_n == n0)
    begin
      mismatches++;
      stop_test();
    end
  endtask

  // Returns at the edge that ends a half-second tick cycle
  task automatic wait_half();
    int n;
    n = 0;
    while (half_tick_o !== 1'b1 && n < 2 * HDIV)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 2 * HDIV)
    begin
      mismatches++;
      stop_test();
    end
  endtask

  initial
  begin
    int k0, k1, k2;
    cal = '0;
    cal.sec_ten = 4'h1;
    cal.sec_one = 4'h2;
    cal.min_ten = 4'h3;
    cal.min_one = 4'h4;
    cal.hour_one = 4'h5;
    cal.wday = 4'h3;
    tick(2);
    rst_i <= 1'b0;
    rd(ALARM_CONFIG_OFS, ALARM_CONFIG_RST);
    rd(WINDOW_OFS, WINDOW_RST);
    rd(CALENDAR_OFS, 16'h3412);
    wr(8'h1C, 16'hFFFF);
    rd(8'h1C, 16'h0000);
    wr(CLOCK_CONFIG_OFS, 16'h8000);
    foreach (rows[i])
    begin
      wr(ALARM_TIME_OFS, rows[i].t);
      wr(ALARM_DATE_OFS, rows[i].d);
      k0 = irq_n;
      wr(ALARM_CONFIG_OFS, {2'b10, rows[i].m, 10'h000});
      k1 = ht_n;
      tick(3 * HDIV);
      chk_reg(16'(irq_n - k0), {15'h0000, rows[i].f});
      chk_reg(16'(ht_n - k1), 16'h0003);
      rd(ALARM_CONFIG_OFS, {~rows[i].f, 1'b0, rows[i].m, 10'h000});
      chk_bit(alarm_pulse_o, irq_n[0]);
      wr(ALARM_CONFIG_OFS, 16'h0000);
    end
    // Pin shows the alarm pulse while its power-control source is not selected
    chk_bit(clock_pin_o, alarm_pulse_o);
    // Repeat count two gives three alarms, then the enable drops
    k0 = irq_n;
    wr(ALARM_CONFIG_OFS, 16'h8002);
    tick(6 * HDIV);
    chk_reg(16'(irq_n - k0), 16'h0003);
    rd(ALARM_CONFIG_OFS, 16'h0000);
    // Written just after a half-second tick, clear of the sync window
    wait_half();
    rd(CLOCK_CONFIG_OFS, 16'h8000);
    wr(ALARM_CONFIG_OFS, 16'hC001);
    repeat (3) wait_irq();
    rd(ALARM_CONFIG_OFS, 16'hC0FE);
    wr(ALARM_CONFIG_OFS, 16'h0000);
    wr(CLOCK_CONFIG_OFS, 16'h8700);
    // Second pass has no stability window, so sampling starts at the alarm
    for (int p = 0; p < 2; p++)
    begin
      pol_b <= p[0];
      wr(WINDOW_OFS, p[0] ? 16'h0003 : 16'h0203);
      wr(POWER_CTRL_OFS, {1'b1, p[0], 14'h0000});
      tick(2);
      chk_bit(power_ctrl_signal_o, pol_b);
      k0 = on_n;
      k1 = samp_n;
      k2 = pin_n;
      wr(ALARM_CONFIG_OFS, 16'hC000);
      wait_irq();
      tick(30);
      chk_reg(16'(on_n - k0), 16'((p[0] ? 3 : 5) * PDIV));
      chk_reg(16'(samp_n - k1), 16'(3 * PDIV));
      chk_reg(16'(pin_n - k2), 16'h0000);
      chk_bit(wake_seen_o, 1'b1);
      rd(POWER_CTRL_OFS, {1'b1, p[0], 14'h0000});
      tick(1);
      chk_bit(wake_seen_o, 1'b0);
      // Endless repeat brings a second power cycle; stop it right after its alarm
      wait_irq();
      wr(ALARM_CONFIG_OFS, 16'h0000);
      tick(30);
      chk_reg(16'(on_n - k0), 16'((p[0] ? 6 : 10) * PDIV));
    end
    // All ones keeps sampling open even with power control off
    wr(POWER_CTRL_OFS, 16'h0000);
    wr(WINDOW_OFS, {8'h00, SAMPLE_ALWAYS});
    tick(2);
    chk_bit(sample_window_o, 1'b1);
    wr(WINDOW_OFS, 16'h0000);
    foreach (secs[i])
    begin
      k0 = cal_n;
      cal.sec_ten <= secs[i][7:4];
      cal.sec_one <= secs[i][3:0];
      tick(4);
      chk_reg(16'(cal_n - k0), {15'h0000, secs[i][8]});
    end
    // Seconds now read 44: a calibration write is safe here
    wr(CLOCK_CONFIG_OFS, 16'h8711);
    // Reset in mid-run with an alarm armed that can never match
    wr(ALARM_CONFIG_OFS, 16'hA800);
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    chk_bit(wake_seen_o, 1'b0);
    rd(ALARM_CONFIG_OFS, ALARM_CONFIG_RST);
    stop_test();
  end
endmodule
`default_nettype wire

/* tb/ext_device_model.sv */
// Model of the external device whose supply the power-control pin switches
// Assumes the pin level is seen directly and the polarity bit is known
`timescale 1ns/100ps
`default_nettype none
module ext_device_model
#(
  parameter int WAKE_DELAY = 3
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic active_low_i,
  output logic wake_o
);
  logic [7:0] up_q;
  logic powered;

  assign powered = pin_i ^ active_low_i;

  // Count cycles since power came up; the device needs time to settle
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !powered)
      up_q <= 8'h00;
    else if (up_q != 8'hFF)
      up_q <= up_q + 8'h01;
  end

  // Unpowered device leaves the wake line to its pull-down
  assign wake_o = powered && (up_q >= WAKE_DELAY[7:0]);
endmodule
`default_nettype wire
